// >>> sece_map.vh
// Purpose: constants for the serial EEPROM command front end
// Assumes: 20 MHz system clock
// Notes: status bit positions and opcodes
`ifndef SECE_MAP_VH
`define SECE_MAP_VH
`define SECE_OP_READ 8'h03
`define SECE_OP_WRITE 8'h02
`define SECE_OP_STAT_WR 8'h01
`define SECE_OP_SET_WE 8'h06
`define SECE_OP_CLR_WE 8'h04
`define SECE_OP_STAT_RD 8'h05
`define SECE_SR_BUSY 0
`define SECE_SR_WEN 1
`define SECE_SR_BP_LO 2
`define SECE_SR_BP_HI 3
`define SECE_SR_PEN 7
`define SECE_SR_RESET 8'h00
`define SECE_ADDR_W 13
`define SECE_PAGE_W 5
`define SECE_TWC_MS 6
`define SECE_CLK_KHZ 20000
`define SECE_TWC_CYC (`SECE_TWC_MS * `SECE_CLK_KHZ)
`endif

// >>> sece_spi_eeprom.v
// Purpose: SPI EEPROM command front end with array, status and pause
// Assumes: serial pins sampled by mclk, link clock far slower than mclk
// Notes: array held in a local memory; write cycle self-timed
//
// Contract
// - Pause starts only with clock low, else at next falling edge.
// - While paused, serial pins ignored and output released; stay selected.
// - Resume only with clock low; sequence continues where it stopped.
// - Pause input low always releases serial output at once.
// - Eight-bit opcode shifted in on rising edges after select.
// - Opcode, address and data go most significant bit first.
// - Opcodes 03 read, 02 write, 01 status write.
// - Opcodes 06 set enable, 04 clear enable, 05 status read.
// - Read is opcode plus 16-bit address, then data out.
// - Read address increments per byte, wraps to zero; deselect ends.
// - Set enable works only if deselected after eight bits.
// - Write is opcode, address, one byte up to a page.
// - Write past page end wraps inside the same page.
// - Write starts only if deselect follows a complete data byte.
// - Array read refused while busy; status read always allowed.
// - Enable latch cleared at reset and after clear, status or array write.
// - Busy bit reads 1 during internal write, else 0.
// - Enable bit mirrors latch; set and clear update it only if deselected after eight bits.
// - Block-protect bits change only by status write.
// - Protect code: none, upper quarter, upper half, whole array.
// - Status write blocked when protect pin low and pin enable set.
// - Internal write finishes within 6 ms from select rise.
// - Output changes after falling serial clock edge.
`timescale 1ns/100ps
`default_nettype none
`include "sece_map.vh"
module sece_spi_eeprom
#(
  parameter TWC_CYCLES = `SECE_TWC_CYC
)
(
  input wire mclk,
  input wire rst_n,
  input wire cs_n,
  input wire sck,
  input wire si,
  input wire hold_n,
  input wire wp_n,
  output reg so,
  output reg so_oe_n,
  output reg write_busy_flag,
  output reg write_enable_flag
);
  localparam ST_OP = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_RDATA = 3'd2;
  localparam ST_WDATA = 3'd3;
  localparam ST_SRD = 3'd4;
  localparam ST_SWR = 3'd5;
  localparam ST_IDLE = 3'd6;
  localparam AW = `SECE_ADDR_W;
  localparam PW = `SECE_PAGE_W;
  localparam PAGE = 1 << PW;
  // ****************************************
  // Pin sampling
  // ****************************************
  reg [2:0] cs_s;
  reg [2:0] sck_s;
  reg [2:0] si_s;
  reg [2:0] hold_s;
  reg [2:0] wp_s;
  reg cs_q;
  reg sck_q;
  reg si_q;
  reg hold_q;
  reg wp_q;
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cs_s <= 3'h7;
      sck_s <= 3'h0;
      si_s <= 3'h0;
      hold_s <= 3'h7;
      wp_s <= 3'h7;
      cs_q <= 1'b1;
      sck_q <= 1'b0;
      si_q <= 1'b0;
      hold_q <= 1'b1;
      wp_q <= 1'b1;
    end
    else
    begin
      cs_s <= {cs_s[1:0], cs_n};
      sck_s <= {sck_s[1:0], sck};
      si_s <= {si_s[1:0], si};
      hold_s <= {hold_s[1:0], hold_n};
      wp_s <= {wp_s[1:0], wp_n};
      if (cs_s[1] == cs_s[2])
        cs_q <= cs_s[2];
      if (sck_s[1] == sck_s[2])
        sck_q <= sck_s[2];
      if (si_s[1] == si_s[2])
        si_q <= si_s[2];
      if (hold_s[1] == hold_s[2])
        hold_q <= hold_s[2];
      if (wp_s[1] == wp_s[2])
        wp_q <= wp_s[2];
    end
  end
  wire cs_act = ~cs_q & (cs_s[1] == cs_s[2] ? ~cs_s[2] : 1'b1);
  wire sck_now = (sck_s[1] == sck_s[2]) ? sck_s[2] : sck_q;
  wire hold_now = (hold_s[1] == hold_s[2]) ? hold_s[2] : hold_q;
  wire sck_rise = ~sck_q & sck_now;
  wire sck_fall = sck_q & ~sck_now;
  wire cs_rise = ~cs_q & (cs_s[1] == cs_s[2]) & cs_s[2];
  // ****************************************
  // Pause control
  // ****************************************
  reg paused;
  reg pause_pend;
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      paused <= 1'b0;
      pause_pend <= 1'b0;
    end
    else if (!cs_act)
    begin
      paused <= 1'b0;
      pause_pend <= 1'b0;
    end
    else if (!hold_now && !paused)
    begin
      if (!sck_now || sck_fall)
      begin
        paused <= 1'b1;
        pause_pend <= 1'b0;
      end
      else
        pause_pend <= 1'b1;
    end
    else if (hold_now && paused && !sck_now)
      paused <= 1'b0;
    else if (hold_now)
      pause_pend <= 1'b0;
  end
  wire run = cs_act & ~paused & ~(pause_pend | (~hold_now & ~sck_now));
  // ****************************************
  // Array, status and write engine
  // ****************************************
  reg [7:0] mem [0:(1<<AW)-1];
  reg [7:0] page_buf [0:PAGE-1];
  reg [PAGE-1:0] page_vld;
  reg [2:0] state;
  reg [7:0] shreg;
  reg [3:0] bitcnt;
  reg [4:0] acnt;
  reg [15:0] addr;
  reg [7:0] opcode;
  reg [7:0] txreg;
  reg byte_done;
  reg set_en_ok;
  reg sr_pend;
  reg wr_pend;
  reg prot_en;
  reg [1:0] bp;
  reg [7:0] sr_new;
  reg [31:0] twc;
  reg cmt_arr;
  reg [PW:0] ci;
  reg [AW-1:0] page_base;
  wire [7:0] shin = {shreg[6:0], si_q};
  wire [7:0] status = {prot_en, 3'h0, bp, write_enable_flag, write_busy_flag};
  wire [AW-1:0] a_lo = addr[AW-1:0];
  wire [AW-1:0] top = {AW{1'b1}};
  wire a_prot = (bp == 2'b11) ||
    (bp == 2'b10 && a_lo[AW-1]) ||
    (bp == 2'b01 && a_lo[AW-1:AW-2] == 2'b11);
  always @(posedge mclk)
  begin
    if (run && sck_rise && state == ST_WDATA && bitcnt == 4'd7)
    begin
      page_buf[a_lo[PW-1:0]] <= shin;
    end
    if (cmt_arr && page_vld[ci[PW-1:0]])
      mem[page_base | {{(AW-PW){1'b0}}, ci[PW-1:0]}] <= page_buf[ci[PW-1:0]];
  end
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_OP;
      shreg <= 8'h00;
      bitcnt <= 4'h0;
      acnt <= 5'h0;
      addr <= 16'h0000;
      opcode <= 8'h00;
      txreg <= 8'h00;
      byte_done <= 1'b0;
      set_en_ok <= 1'b0;
      sr_pend <= 1'b0;
      wr_pend <= 1'b0;
      prot_en <= 1'b0;
      bp <= 2'b00;
      sr_new <= `SECE_SR_RESET;
      twc <= 32'h0;
      cmt_arr <= 1'b0;
      ci <= {(PW+1){1'b0}};
      page_base <= {AW{1'b0}};
      page_vld <= {PAGE{1'b0}};
      write_busy_flag <= 1'b0;
      write_enable_flag <= 1'b0;
      so <= 1'b1;
      so_oe_n <= 1'b1;
    end
    else
    begin
      if (cmt_arr)
      begin
        ci <= ci + 1'b1;
        if (ci == PAGE - 1)
          cmt_arr <= 1'b0;
      end
      if (write_busy_flag)
      begin
        if (twc == 32'h0)
          write_busy_flag <= 1'b0;
        else
          twc <= twc - 32'h1;
      end
      so_oe_n <= ~(run && (state == ST_RDATA || state == ST_SRD) && hold_now);
      if (!cs_act)
      begin
        if (cs_rise)
        begin
          if (state == ST_OP && bitcnt == 4'd0 && set_en_ok)
            write_enable_flag <= 1'b1;
          if (state == ST_OP && bitcnt == 4'd0 && opcode == `SECE_OP_CLR_WE)
            write_enable_flag <= 1'b0;
          if ((wr_pend || sr_pend) && byte_done && write_enable_flag &&
              !write_busy_flag)
          begin
            write_busy_flag <= 1'b1;
            twc <= TWC_CYCLES - 1;
            write_enable_flag <= 1'b0;
            if (wr_pend)
            begin
              cmt_arr <= 1'b1;
              ci <= {(PW+1){1'b0}};
            end
            else if (!(prot_en && !wp_q))
            begin
              prot_en <= sr_new[`SECE_SR_PEN];
              bp <= sr_new[`SECE_SR_BP_HI:`SECE_SR_BP_LO];
            end
          end
        end
        state <= ST_OP;
        bitcnt <= 4'h0;
        acnt <= 5'h0;
        set_en_ok <= 1'b0;
        wr_pend <= 1'b0;
        sr_pend <= 1'b0;
        byte_done <= 1'b0;
        so <= 1'b1;
      end
      else if (run && sck_rise)
      begin
        shreg <= shin;
        bitcnt <= (bitcnt == 4'd7) ? 4'd0 : bitcnt + 4'd1;
        byte_done <= (bitcnt == 4'd7);
        set_en_ok <= 1'b0;
        case (state)
          ST_OP:
            if (bitcnt == 4'd7)
            begin
              opcode <= shin;
              if (shin == `SECE_OP_READ || shin == `SECE_OP_WRITE)
                state <= ST_ADDR;
              else if (shin == `SECE_OP_STAT_WR)
                state <= ST_SWR;
              else if (shin == `SECE_OP_STAT_RD)
              begin
                state <= ST_SRD;
                txreg <= status;
              end
              else if (shin == `SECE_OP_SET_WE)
              begin
                set_en_ok <= 1'b1;
                state <= ST_OP;
              end
              else if (shin == `SECE_OP_CLR_WE)
                state <= ST_OP;
              else
                state <= ST_IDLE;
            end
          ST_ADDR:
          begin
            addr <= {addr[14:0], si_q};
            acnt <= acnt + 5'd1;
            bitcnt <= 4'h0;
            byte_done <= 1'b0;
            if (acnt == 5'd15)
            begin
              if (opcode == `SECE_OP_READ)
              begin
                if (write_busy_flag)
                  state <= ST_IDLE;
                else
                begin
                  state <= ST_RDATA;
                  txreg <= mem[{addr[AW-2:0], si_q}];
                end
              end
              else
              begin
                state <= ST_WDATA;
                page_vld <= {PAGE{1'b0}};
                page_base <= {addr[AW-2:PW-1], {PW{1'b0}}};
              end
            end
          end
          ST_RDATA:
            if (bitcnt == 4'd7)
            begin
              addr <= (a_lo == top) ? 16'h0000 : addr + 16'h1;
              txreg <= mem[(a_lo == top) ? {AW{1'b0}} : a_lo + 1'b1];
            end
          ST_SRD:
            if (bitcnt == 4'd7)
              txreg <= status;
          ST_WDATA:
            if (bitcnt == 4'd7)
            begin
              wr_pend <= write_enable_flag && !a_prot;
              page_vld[a_lo[PW-1:0]] <= 1'b1;
              addr <= {addr[15:PW], a_lo[PW-1:0] + 1'b1};
            end
          ST_SWR:
            if (bitcnt == 4'd7)
            begin
              sr_new <= shin;
              sr_pend <= 1'b1;
              state <= ST_IDLE;
            end
          default:
            state <= ST_IDLE;
        endcase
      end
      // Fall that starts a pause still moves so on
      else if (cs_act && !paused && sck_fall && (state == ST_RDATA || state == ST_SRD))
      begin
        so <= txreg[3'd7 - bitcnt[2:0]];
      end
    end
  end
endmodule
`default_nettype wire

// >>> sece_spi_eeprom_checker.sv
// Purpose: port checker for the SPI EEPROM front end
// Assumes: one mclk domain
// Notes: bound from the bench top file
`timescale 1ns/100ps
`default_nettype none
module sece_spi_eeprom_checker
#(
  parameter int TWC_CYCLES = 1000
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic hold_n,
  input wire logic so_oe_n,
  input wire logic write_busy_flag,
  input wire logic write_enable_flag
);
  // ****
  // Properties
  // ****
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  int busy_cnt;
  always @(posedge mclk or negedge rst_n)
    if (!rst_n)
      busy_cnt <= 0;
    else
      busy_cnt <= write_busy_flag ? busy_cnt + 1 : 0;
  sequence s_desel;
    cs_n [*5];
  endsequence
  sequence s_paused;
    !hold_n [*5];
  endsequence
  a_desel_release: assert property (s_desel |-> so_oe_n)
    else $error("so driven while deselected");
  a_hold_release: assert property (s_paused |-> so_oe_n)
    else $error("so driven while paused");
  a_latch_after_desel: assert property ($rose(write_enable_flag) |-> $past(cs_n, 2))
    else $error("enable latch set without deselect");
  a_busy_after_desel: assert property ($rose(write_busy_flag) |-> $past(cs_n, 2))
    else $error("write started while selected");
  a_busy_needs_wel: assert property ($rose(write_busy_flag) |-> $past(write_enable_flag))
    else $error("write started with latch clear");
  a_busy_bounded: assert property (busy_cnt <= TWC_CYCLES + 2)
    else $error("write cycle too long");
  a_latch_cleared: assert property ($fell(write_busy_flag) |-> ##[0:2] !write_enable_flag)
    else $error("latch still set after write");
  a_reset_state: assert property ($rose(rst_n) |-> !write_busy_flag && !write_enable_flag)
    else $error("flags set after reset");
endmodule
`default_nettype wire

// >>> sece_host.sv
// Purpose: SPI host model for the bench
// Assumes: sck period 8 mclk, idles low
// Notes: so reads high while released
`timescale 1ns/100ps
`default_nettype none
module sece_host
(
  input wire logic mclk,
  input wire logic so,
  input wire logic so_oe_n,
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic hold_n
);
  // ****
  // Frame tasks
  // ****
  initial
  begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic sel();
    cs_n <= 1'b0;
    wt(4);
  endtask
  task automatic desel();
    wt(4);
    cs_n <= 1'b1;
    si <= ~si;
    wt(8);
  endtask
  task automatic xb(input logic [7:0] d, input int nb, output logic [7:0] q, input int hp = -1);
    q = 8'hFF;
    for (int i = 7; i > 7 - nb; i--)
    begin
      si <= d[i];
      wt(4);
      sck <= 1'b1;
      wt(2);
      if (i == hp)
        hold_n <= 1'b0;
      wt(2);
      q[i] = so_oe_n ? 1'b1 : so;
      sck <= 1'b0;
      if (i == hp)
        pause();
    end
  endtask
  task automatic pause();
    hold_n <= 1'b0;
    repeat (4)
    begin
      wt(4);
      sck <= ~sck;
      si <= ~si;
    end
    wt(4);
    hold_n <= 1'b1;
    wt(4);
  endtask
endmodule
`default_nettype wire

// >>> sece_spi_eeprom_tb.sv
// Purpose: self-checking bench for the SPI EEPROM front end
// Assumes: write cycle cut to 1000 mclk
// Notes: random data from a fixed seed
`timescale 1ns/100ps
`default_nettype none
module sece_spi_eeprom_tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic wp_n = 1'b1;
  wire cs_n, sck, si, hold_n, so, so_oe_n, busy, we_flag;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  int seed = 5768;
  logic [7:0] d [4];
  logic [7:0] r [4];
  logic [7:0] mem [int];
  sece_spi_eeprom #(.TWC_CYCLES(1000)) u_sece_spi_eeprom (.mclk(mclk), .rst_n(rst_n),
    .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so(so),
    .so_oe_n(so_oe_n), .write_busy_flag(busy), .write_enable_flag(we_flag));
  sece_host u_sece_host (.mclk(mclk), .so(so), .so_oe_n(so_oe_n), .cs_n(cs_n),
    .sck(sck), .si(si), .hold_n(hold_n));
  // ****
  // Tasks
  // ****
  initial
  begin
    forever #25 mclk = ~mclk;
  end
  task automatic end_sim();
    $display("Counts: %0d checks, %0d errors", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      error_cnt++;
      end_sim();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] pg(input logic [15:0] a, input int k);
    return {a[15:5], a[4:0] + 5'(k)};
  endfunction
  task automatic cmd(input logic [7:0] op, input logic [7:0] arg, input int n);
    logic [7:0] q;
    u_sece_host.sel();
    u_sece_host.xb(op, 8, q);
    if (n > 0)
      u_sece_host.xb(arg, 8, r[0]);
    u_sece_host.desel();
  endtask
  task automatic hdr(input logic [7:0] op, input logic [15:0] a);
    logic [7:0] q;
    u_sece_host.sel();
    u_sece_host.xb(op, 8, q);
    u_sece_host.xb(a[15:8], 8, q);
    u_sece_host.xb(a[7:0], 8, q);
  endtask
  task automatic wr(input logic [15:0] a, input int n, input int lb);
    logic [7:0] q;
    hdr(8'h02, a);
    for (int i = 0; i < n; i++)
      u_sece_host.xb(d[i], (i == n - 1) ? lb : 8, q);
    u_sece_host.desel();
  endtask
  task automatic rd(input logic [15:0] a, input int n, input int p);
    hdr(8'h03, a);
    for (int i = 0; i < n; i++)
    begin
      if (i == p)
        u_sece_host.pause();
      u_sece_host.xb(8'h00, 8, r[i], (i == p) ? 4 : -1);
    end
    u_sece_host.desel();
  endtask
  task automatic wb(input logic v);
    int n;
    n = 0;
    while (busy !== v && n < 2000)
    begin
      @(posedge mclk);
      n++;
    end
    chk({7'h00, busy}, {7'h00, v});
  endtask
  task automatic sr(input logic [7:0] m, input logic [7:0] e);
    cmd(8'h05, 8'hFF, 1);
    chk(r[0] & m, e);
  endtask
  // ****
  // Sequence
  // ****
  initial
  begin
    for (int i = 0; i < 4; i++)
      d[i] = 8'($random(seed));
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    sr(8'h8F, 8'h00);
    cmd(8'h06, 8'h00, 1);
    sr(8'h8F, 8'h00);
    cmd(8'h06, 8'h00, 0);
    sr(8'h8F, 8'h02);
    cmd(8'h04, 8'h00, 0);
    sr(8'h8F, 8'h00);
    $display("Test latch done");
    wr(16'h001F, 3, 8);
    chk({7'h00, busy}, 8'h00);
    cmd(8'h06, 8'h00, 0);
    wr(16'h001F, 3, 8);
    wb(1'b1);
    sr(8'h01, 8'h01);
    rd(16'h001F, 1, 9);
    chk(r[0], 8'hFF);
    wb(1'b0);
    for (int i = 0; i < 3; i++)
      mem[pg(16'h001F, i)] = d[i];
    rd(16'h0000, 2, 1);
    chk(r[0], mem[0]);
    chk(r[1], mem[1]);
    sr(8'h8F, 8'h00);
    cmd(8'h06, 8'h00, 0);
    wr(16'h1FFF, 1, 8);
    wb(1'b1);
    wb(1'b0);
    mem[16'h1FFF] = d[0];
    rd(16'h1FFF, 2, 9);
    chk(r[0], mem[16'h1FFF]);
    chk(r[1], mem[0]);
    cmd(8'h06, 8'h00, 0);
    wr(16'h0040, 1, 5);
    chk({7'h00, busy}, 8'h00);
    $display("Test array done");
    cmd(8'h04, 8'h00, 0);
    cmd(8'h06, 8'h00, 0);
    cmd(8'h01, 8'h8C, 1);
    wb(1'b0);
    sr(8'h8F, 8'h8C);
    cmd(8'h06, 8'h00, 0);
    wr(16'h0000, 1, 8);
    chk({7'h00, busy}, 8'h00);
    wp_n <= 1'b0;
    cmd(8'h06, 8'h00, 0);
    cmd(8'h01, 8'h00, 1);
    wb(1'b0);
    sr(8'h8F, 8'h8C);
    wp_n <= 1'b1;
    cmd(8'h06, 8'h00, 0);
    cmd(8'h01, 8'h00, 1);
    wb(1'b0);
    sr(8'h8F, 8'h00);
    cmd(8'hA5, 8'h00, 1);
    chk(r[0], 8'hFF);
    $display("Test status done");
    end_sim();
  end
endmodule
bind sece_spi_eeprom sece_spi_eeprom_checker #(.TWC_CYCLES(TWC_CYCLES)) u_chk (.mclk(mclk),
  .rst_n(rst_n), .cs_n(cs_n), .hold_n(hold_n), .so_oe_n(so_oe_n),
  .write_busy_flag(write_busy_flag), .write_enable_flag(write_enable_flag));
`default_nettype wire
